// file: common/iprs_pkg.sv
package iprs_pkg;

    // Port geometry
    localparam int PIN_COUNT  = 8;
    localparam int DM_BITS    = 3;
    localparam int EDGE_BITS  = 2;
    localparam int SEL_BITS   = 2;
    localparam int DSI_SIGS   = 4;
    localparam int EMIF_BITS  = 3;
    localparam int PIN_IDX_W  = 3;

    // Reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_EDGES = 16'h0000;

    // Port control field positions
    localparam int CTL_EMIF_LSB = 0;
    localparam int CTL_VTRIP_BIT = 3;

    // Field layout shared by the port-wide and per-pin aliases
    localparam int AL_DATA_BIT  = 0;
    localparam int AL_BYP_BIT   = 1;
    localparam int AL_DM_LSB    = 2;
    localparam int AL_SLW_BIT   = 5;
    localparam int AL_BIE_BIT   = 6;
    localparam int AL_INDIS_BIT = 7;

    // Edge type encodings, one field per pin
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Stored registers come first; their enum position is their array index
    localparam int NUM_STORED = 23;

    typedef enum logic [4:0] {
        REG_OUT_DATA, REG_DRIVE0, REG_DRIVE1, REG_DRIVE2, REG_SLEW, REG_BYPASS,
        REG_BIDIR, REG_IN_DIS, REG_MASK, REG_AGLOBAL, REG_AMUXBUS, REG_PORT_CTRL,
        REG_LCD_ROLE, REG_LCD_DRIVE, REG_PAIR_REF, REG_PAIR_BUF, REG_HYST,
        REG_OSEL0, REG_OSEL1, REG_OESEL0, REG_OESEL1, REG_DSYNC_IN, REG_OUT_SYNC,
        REG_PIN_LEVEL, REG_OUT_WIN, REG_LEVEL_WIN, REG_PORT_ALIAS, REG_PIN_ALIAS,
        REG_EDGE_TYPE, REG_IRQ_STATUS, REG_SNAPSHOT
    } iprs_reg_t;

endpackage

// file: hdl/iprs_pin_irq.sv
`timescale 1ns/100ps
module iprs_pin_irq
    import iprs_pkg::*;
(
    input  wire logic                            clk_sys,
    input  wire logic                            arst_n,
    input  wire logic [iprs_pkg::PIN_COUNT-1:0]  pinLevel,
    input  wire logic [2*iprs_pkg::PIN_COUNT-1:0] edgeType,
    input  wire logic                            statusRead,
    input  wire logic                            wakeIn,
    output logic      [iprs_pkg::PIN_COUNT-1:0]  status,
    output logic      [iprs_pkg::PIN_COUNT-1:0]  snapshot,
    output logic                                 irqReq,
    output logic                                 wakeOut
);
    logic [PIN_COUNT-1:0] prevLevel_ff;   // Last sampled levels
    logic [PIN_COUNT-1:0] status_ff;      // Posted edges
    logic [PIN_COUNT-1:0] snap_ff;        // Levels at last status read
    logic [PIN_COUNT-1:0] nxt_prevLevel;
    logic [PIN_COUNT-1:0] nxt_status;
    logic [PIN_COUNT-1:0] nxt_snap;
    logic [PIN_COUNT-1:0] edgeHit;        // Selected edge seen this cycle

    // Per-pin edge detection
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_edge
        logic [EDGE_BITS-1:0] kind;
        logic                 rise;
        logic                 fall;
        assign kind = edgeType[p*EDGE_BITS +: EDGE_BITS];
        assign rise = pinLevel[p] & ~prevLevel_ff[p];
        assign fall = ~pinLevel[p] & prevLevel_ff[p];
        assign edgeHit[p] = ((kind == EDGE_RISE) & rise) | ((kind == EDGE_FALL) & fall) |
                            ((kind == EDGE_BOTH) & (rise | fall));
    end

    // Status, snapshot and history next values
    always_comb begin
        nxt_prevLevel = pinLevel;
        nxt_snap      = snap_ff;
        if (statusRead) begin
            // Pending pins drop their events this cycle; idle pins still post
            nxt_status = edgeHit & ~status_ff;
            nxt_snap   = pinLevel;
        end else begin
            nxt_status = status_ff | edgeHit;
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prevLevel_ff <= '0;
            status_ff    <= '0;
            snap_ff      <= '0;
        end else begin
            prevLevel_ff <= nxt_prevLevel;
            status_ff    <= nxt_status;
            snap_ff      <= nxt_snap;
        end
    end

    assign status   = status_ff;
    assign snapshot = snap_ff;
    assign irqReq   = |status_ff;
    assign wakeOut  = wakeIn | (|status_ff);

endmodule // iprs_pin_irq

// file: hdl/iprs_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Pin output follows data register
// - Pin level read ignores data register
// - Three drive registers set pin modes
// - Slew register drives output slew
// - Bypass picks data register or interconnect
// - Bidir bit enables dynamic output enable
// - Input disable overrides drive-mode buffer
// - Mask gates aliased data and levels
// - Windows give masked access for DMA
// - Per-pin analog global and mux connects
// - Port and pin aliases touch fields
// - Control holds memory-if field, threshold
// - LCD role select and pin release
// - Pair reference select, two bits each
// - Pair buffer config and hysteresis enable
// - Two-bit selects for data and enable
// - Optional double sync toward logic
// - Output sync through data register flops
// - Edge type register per pin
// - Status shows posted pin interrupts
// - Snapshot levels on status read
// - Rise, fall or either; no level
// - Edge sets status and requests interrupt
// - Read clears; pending pins blocked meanwhile
module iprs_port
    import iprs_pkg::*;
(
    input  wire logic                                  clk_sys,
    input  wire logic                                  arst_n,
    input  wire logic                                  cfgWrEn,
    input  wire iprs_pkg::iprs_reg_t                   cfgWrSel,
    input  wire logic [iprs_pkg::PIN_IDX_W-1:0]        cfgWrPin,
    input  wire logic [7:0]                            cfgWrData,
    input  wire logic                                  cfgRdEn,
    input  wire iprs_pkg::iprs_reg_t                   cfgRdSel,
    input  wire logic [iprs_pkg::PIN_IDX_W-1:0]        cfgRdPin,
    output logic      [7:0]                            cfgRdData,
    input  wire logic [iprs_pkg::PIN_COUNT-1:0]        padIn,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        padOut,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        padOeN,
    output logic      [iprs_pkg::PIN_COUNT*iprs_pkg::DM_BITS-1:0] padDriveMode,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        padSlew,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        padInBufEn,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        analogGlobalConnect,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        analogMuxConnect,
    output logic      [iprs_pkg::EMIF_BITS-1:0]        extMemoryIfConfig,
    output logic                                       inputThresholdSel,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        lcdCommonSegmentSelect,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        lcdDriveEnable,
    output logic      [7:0]                            pairReferenceSelect,
    output logic      [7:0]                            pairBufferConfig,
    output logic      [7:0]                            diffHysteresisEnable,
    input  wire logic [iprs_pkg::DSI_SIGS-1:0]         dsiDataIn,
    input  wire logic [iprs_pkg::DSI_SIGS-1:0]         dsiOeIn,
    output logic      [iprs_pkg::PIN_COUNT-1:0]        dsiPinData,
    input  wire logic                                  wakeIn,
    output logic                                       wakeOut,
    output logic                                       irqReq
);
    // Register array indices
    localparam int IX_DATA  = int'(REG_OUT_DATA);
    localparam int IX_DM0   = int'(REG_DRIVE0);
    localparam int IX_DM1   = int'(REG_DRIVE1);
    localparam int IX_DM2   = int'(REG_DRIVE2);
    localparam int IX_SLW   = int'(REG_SLEW);
    localparam int IX_BYP   = int'(REG_BYPASS);
    localparam int IX_BIE   = int'(REG_BIDIR);
    localparam int IX_INDIS = int'(REG_IN_DIS);
    localparam int IX_MASK  = int'(REG_MASK);
    localparam int IX_AG    = int'(REG_AGLOBAL);
    localparam int IX_AMX   = int'(REG_AMUXBUS);
    localparam int IX_CTL   = int'(REG_PORT_CTRL);
    localparam int IX_LROLE = int'(REG_LCD_ROLE);
    localparam int IX_LEN   = int'(REG_LCD_DRIVE);
    localparam int IX_PREF  = int'(REG_PAIR_REF);
    localparam int IX_PBUF  = int'(REG_PAIR_BUF);
    localparam int IX_HYST  = int'(REG_HYST);
    localparam int IX_OS0   = int'(REG_OSEL0);
    localparam int IX_OS1   = int'(REG_OSEL1);
    localparam int IX_OE0   = int'(REG_OESEL0);
    localparam int IX_OE1   = int'(REG_OESEL1);
    localparam int IX_DSYN  = int'(REG_DSYNC_IN);
    localparam int IX_OSYN  = int'(REG_OUT_SYNC);

    logic [7:0]                 cfg_ff [NUM_STORED];    // Functional registers
    logic [7:0]                 nxt_cfg [NUM_STORED];
    logic [2*PIN_COUNT-1:0]     edgeType_ff;            // Per-pin edge kinds
    logic [2*PIN_COUNT-1:0]     nxt_edgeType;
    logic [7:0]                 rdData_ff;              // Read data holding
    logic [7:0]                 nxt_rdData;
    logic [PIN_COUNT-1:0]       padOut_ff;              // Registered pad data
    logic [PIN_COUNT-1:0]       padOeN_ff;              // Registered pad enable
    logic [PIN_COUNT-1:0]       nxt_padOut;
    logic [PIN_COUNT-1:0]       nxt_padOeN;
    logic [PIN_COUNT-1:0]       intercOut;              // Selected array data
    logic [PIN_COUNT-1:0]       intercOe;               // Selected array enable
    logic [PIN_COUNT-1:0]       syncedIn;               // Double-synced pins
    logic [PIN_COUNT-1:0]       irqStatus;
    logic [PIN_COUNT-1:0]       irqSnap;
    logic                       statusRead;
    logic [7:0]                 pinView [PIN_COUNT];    // Per-pin alias view

    // Per-pin interconnect selection and alias view
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        logic [SEL_BITS-1:0] outSel;
        logic [SEL_BITS-1:0] oeSel;
        assign outSel       = {cfg_ff[IX_OS1][p], cfg_ff[IX_OS0][p]};
        assign oeSel        = {cfg_ff[IX_OE1][p], cfg_ff[IX_OE0][p]};
        assign intercOut[p] = dsiDataIn[outSel];
        assign intercOe[p]  = dsiOeIn[oeSel];
        // Field gather for pin alias reads
        always_comb begin
            pinView[p]                                = '0;
            pinView[p][AL_DATA_BIT]                   = cfg_ff[IX_DATA][p];
            pinView[p][AL_BYP_BIT]                    = cfg_ff[IX_BYP][p];
            pinView[p][AL_DM_LSB +: DM_BITS]          = {cfg_ff[IX_DM2][p], cfg_ff[IX_DM1][p], cfg_ff[IX_DM0][p]};
            pinView[p][AL_SLW_BIT]                    = cfg_ff[IX_SLW][p];
            pinView[p][AL_BIE_BIT]                    = cfg_ff[IX_BIE][p];
            pinView[p][AL_INDIS_BIT]                  = cfg_ff[IX_INDIS][p];
        end
        assign padDriveMode[p*DM_BITS +: DM_BITS] = {cfg_ff[IX_DM2][p], cfg_ff[IX_DM1][p], cfg_ff[IX_DM0][p]};
        assign padInBufEn[p] = (padDriveMode[p*DM_BITS +: DM_BITS] != '0) & ~cfg_ff[IX_INDIS][p];
    end

    iprs_sync2 #(
        .WIDTH (PIN_COUNT)
    ) u_in_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .dataIn  (padIn),
        .dataOut (syncedIn)
    );
    assign dsiPinData = (syncedIn & cfg_ff[IX_DSYN]) | (padIn & ~cfg_ff[IX_DSYN]);

    // Pin interrupt unit
    assign statusRead = cfgRdEn && (cfgRdSel == REG_IRQ_STATUS);
    iprs_pin_irq u_pin_irq (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .pinLevel   (padIn),
        .edgeType   (edgeType_ff),
        .statusRead (statusRead),
        .wakeIn     (wakeIn),
        .status     (irqStatus),
        .snapshot   (irqSnap),
        .irqReq     (irqReq),
        .wakeOut    (wakeOut)
    );

    // Register next values: software writes, aliases, output sync
    always_comb begin
        nxt_cfg      = cfg_ff;
        nxt_edgeType = edgeType_ff;
        if (cfgWrEn) begin
            if (cfgWrSel == REG_OUT_WIN) begin
                nxt_cfg[IX_DATA] = (cfg_ff[IX_DATA] & ~cfg_ff[IX_MASK]) | (cfgWrData & cfg_ff[IX_MASK]);
            end else if ((cfgWrSel == REG_PORT_ALIAS) || (cfgWrSel == REG_PIN_ALIAS)) begin
                for (int p = 0; p < PIN_COUNT; p++) begin
                    if ((cfgWrSel == REG_PORT_ALIAS) || (PIN_IDX_W'(p) == cfgWrPin)) begin
                        nxt_cfg[IX_DATA][p]  = cfgWrData[AL_DATA_BIT];
                        nxt_cfg[IX_BYP][p]   = cfgWrData[AL_BYP_BIT];
                        nxt_cfg[IX_DM0][p]   = cfgWrData[AL_DM_LSB];
                        nxt_cfg[IX_DM1][p]   = cfgWrData[AL_DM_LSB + 1];
                        nxt_cfg[IX_DM2][p]   = cfgWrData[AL_DM_LSB + 2];
                        nxt_cfg[IX_SLW][p]   = cfgWrData[AL_SLW_BIT];
                        nxt_cfg[IX_BIE][p]   = cfgWrData[AL_BIE_BIT];
                        nxt_cfg[IX_INDIS][p] = cfgWrData[AL_INDIS_BIT];
                    end
                end
            end else if (cfgWrSel == REG_EDGE_TYPE) begin
                nxt_edgeType[cfgWrPin*EDGE_BITS +: EDGE_BITS] = cfgWrData[EDGE_BITS-1:0];
            end else if (int'(cfgWrSel) < NUM_STORED) begin
                nxt_cfg[int'(cfgWrSel)] = cfgWrData;
            end
        end
        // Sync through data flops
        // Hardware capture wins over a software write on bypassed synced pins
        for (int p = 0; p < PIN_COUNT; p++) begin
            if (cfg_ff[IX_BYP][p] && cfg_ff[IX_OSYN][p]) begin
                nxt_cfg[IX_DATA][p] = intercOut[p];
            end
        end
    end

    // Pad drive next values
    always_comb begin
        for (int p = 0; p < PIN_COUNT; p++) begin
            if (!cfg_ff[IX_BYP][p]) begin
                nxt_padOut[p] = cfg_ff[IX_DATA][p];
            end else if (cfg_ff[IX_OSYN][p]) begin
                nxt_padOut[p] = cfg_ff[IX_DATA][p];
            end else begin
                nxt_padOut[p] = intercOut[p];
            end
            nxt_padOeN[p] = cfg_ff[IX_LEN][p] | (cfg_ff[IX_BIE][p] & ~intercOe[p]);
        end
    end

    // Read data selection; taken one cycle after the request
    always_comb begin
        nxt_rdData = rdData_ff;
        if (cfgRdEn) begin
            if (cfgRdSel == REG_PIN_LEVEL) begin
                nxt_rdData = padIn;
            end else if (cfgRdSel == REG_OUT_WIN) begin
                nxt_rdData = cfg_ff[IX_DATA] & cfg_ff[IX_MASK];
            end else if (cfgRdSel == REG_LEVEL_WIN) begin
                nxt_rdData = padIn & cfg_ff[IX_MASK];
            end else if (cfgRdSel == REG_PORT_ALIAS) begin
                // Port view shows pin zero fields
                nxt_rdData = pinView[0];
            end else if (cfgRdSel == REG_PIN_ALIAS) begin
                nxt_rdData = pinView[cfgRdPin];
            end else if (cfgRdSel == REG_EDGE_TYPE) begin
                nxt_rdData = 8'(edgeType_ff[cfgRdPin*EDGE_BITS +: EDGE_BITS]);
            end else if (cfgRdSel == REG_IRQ_STATUS) begin
                nxt_rdData = irqStatus;
            end else if (cfgRdSel == REG_SNAPSHOT) begin
                nxt_rdData = irqSnap;
            end else if (int'(cfgRdSel) < NUM_STORED) begin
                nxt_rdData = cfg_ff[int'(cfgRdSel)];
            end else begin
                nxt_rdData = RST_BYTE;
            end
        end
    end

    // All state registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_STORED; i++) begin
                cfg_ff[i] <= RST_BYTE;
            end
            edgeType_ff <= RST_EDGES;
            rdData_ff   <= RST_BYTE;
            padOut_ff   <= '0;
            padOeN_ff   <= '1;
        end else begin
            cfg_ff      <= nxt_cfg;
            edgeType_ff <= nxt_edgeType;
            rdData_ff   <= nxt_rdData;
            padOut_ff   <= nxt_padOut;
            padOeN_ff   <= nxt_padOeN;
        end
    end

    // Register-driven outputs
    assign cfgRdData              = rdData_ff;
    assign padOut                 = padOut_ff;
    assign padOeN                 = padOeN_ff;
    assign padSlew                = cfg_ff[IX_SLW];
    assign analogGlobalConnect    = cfg_ff[IX_AG];
    assign analogMuxConnect       = cfg_ff[IX_AMX];
    assign extMemoryIfConfig      = cfg_ff[IX_CTL][CTL_EMIF_LSB +: EMIF_BITS];
    assign inputThresholdSel      = cfg_ff[IX_CTL][CTL_VTRIP_BIT];
    assign lcdCommonSegmentSelect = cfg_ff[IX_LROLE] & cfg_ff[IX_LEN];
    assign lcdDriveEnable         = cfg_ff[IX_LEN];
    assign pairReferenceSelect    = cfg_ff[IX_PREF];
    assign pairBufferConfig       = cfg_ff[IX_PBUF];
    assign diffHysteresisEnable   = cfg_ff[IX_HYST];

endmodule // iprs_port

// file: hdl/iprs_sync2.sv
`timescale 1ns/100ps
module iprs_sync2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] dataIn,
    output logic      [WIDTH-1:0] dataOut
);
    logic [WIDTH-1:0] stage1_ff;      // First stage, read by second only
    logic [WIDTH-1:0] stage2_ff;      // Settled copy
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_stage2;

    // Next values of both stages
    always_comb begin
        nxt_stage1 = dataIn;
        nxt_stage2 = stage1_ff;
    end

    // Stage registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign dataOut = stage2_ff;

endmodule // iprs_sync2

// file: tb/iprs_pad_model.sv
`timescale 1ns/100ps
module iprs_pad_model (
    input  wire logic [iprs_pkg::PIN_COUNT-1:0] padOut,
    input  wire logic [iprs_pkg::PIN_COUNT-1:0] padOeN,
    input  wire logic [iprs_pkg::PIN_COUNT-1:0] extLevel,
    output logic      [iprs_pkg::PIN_COUNT-1:0] padIn
);
    // Driven pins echo the port; released pins show the outside circuit
    always_comb begin
        for (int i = 0; i < iprs_pkg::PIN_COUNT; i++) begin
            padIn[i] = padOeN[i] ? extLevel[i] : padOut[i];
        end
    end
endmodule // iprs_pad_model

// file: tb/iprs_port_assertions.sv
`timescale 1ns/100ps
module iprs_port_checker
    import iprs_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                arst_n,
    input wire logic                cfgWrEn,
    input wire iprs_pkg::iprs_reg_t cfgWrSel,
    input wire logic [7:0]          cfgWrData,
    input wire logic                cfgRdEn,
    input wire iprs_pkg::iprs_reg_t cfgRdSel,
    input wire logic [7:0]          cfgRdData,
    input wire logic [7:0]          padIn,
    input wire logic [23:0]         padDriveMode,
    input wire logic [7:0]          padInBufEn,
    input wire logic [7:0]          analogGlobalConnect,
    input wire logic [2:0]          extMemoryIfConfig,
    input wire logic                inputThresholdSel,
    input wire logic                wakeIn,
    input wire logic                wakeOut,
    input wire logic                irqReq
);
    // One clock domain, so one clocking and one reset guard
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_wake_chain:
        assert property (wakeOut == (wakeIn | irqReq)) else $error("wake chain wrong");
    chk_level_read:
        assert property (cfgRdEn && cfgRdSel == REG_PIN_LEVEL |=> cfgRdData == $past(padIn)) else $error("pin level read wrong");
    chk_read_holds:
        assert property (!cfgRdEn |=> $stable(cfgRdData)) else $error("read data moved");
    chk_idle_status:
        assert property (cfgRdEn && cfgRdSel == REG_IRQ_STATUS && !irqReq |=> cfgRdData == 8'h00) else $error("status not clear");
    chk_bufen_cause:
        assert property ($changed(padInBufEn) |-> $past(cfgWrEn)) else $error("buffer enable moved alone");
    chk_ctrl_fields:
        assert property (cfgWrEn && cfgWrSel == REG_PORT_CTRL |=> extMemoryIfConfig == $past(cfgWrData[2:0])
            && inputThresholdSel == $past(cfgWrData[3])) else $error("control fields wrong");
    chk_analog_global:
        assert property (cfgWrEn && cfgWrSel == REG_AGLOBAL |=> analogGlobalConnect == $past(cfgWrData))
            else $error("analog connect wrong");
    chk_drive_bits:
        assert property (cfgWrEn && cfgWrSel == REG_DRIVE0 |=> padDriveMode[0] == $past(cfgWrData[0])
            && padDriveMode[3] == $past(cfgWrData[1])) else $error("drive mode wrong");
endmodule // iprs_port_checker

bind iprs_port iprs_port_checker u_chk (.clk_sys, .arst_n, .cfgWrEn, .cfgWrSel, .cfgWrData, .cfgRdEn, .cfgRdSel,
    .cfgRdData, .padIn, .padDriveMode, .padInBufEn, .analogGlobalConnect, .extMemoryIfConfig, .inputThresholdSel,
    .wakeIn, .wakeOut, .irqReq);

// file: tb/iprs_port_tb_top.sv
`timescale 1ns/100ps
module iprs_port_tb_top;
    import iprs_pkg::*;
    logic        clk_sys, arst_n, cfgWrEn, cfgRdEn, wakeIn, probe;
    iprs_reg_t   cfgWrSel, cfgRdSel;
    logic [2:0]  cfgWrPin, cfgRdPin;
    logic [7:0]  cfgWrData, cfgRdData, padIn, padOut, padOeN, extLevel, rv, m, w, dsiPinData;
    logic [3:0]  dsiDataIn, dsiOeIn;
    logic [9:0]  expQ[$];       // Top two bits pick read data, padOut, padOeN or dsiPinData
    logic [9:0]  e9;
    logic        rdPend = 1'h0; // Read answer due this edge
    logic [31:0] seed = 32'h0001518F;
    int          err_total = 0;
    int          tests_run = 0;

    iprs_port DUT (.clk_sys, .arst_n, .cfgWrEn, .cfgWrSel, .cfgWrPin, .cfgWrData, .cfgRdEn, .cfgRdSel, .cfgRdPin,
        .cfgRdData, .padIn, .padOut, .padOeN, .padDriveMode(), .padSlew(), .padInBufEn(), .analogGlobalConnect(),
        .analogMuxConnect(), .extMemoryIfConfig(), .inputThresholdSel(), .lcdCommonSegmentSelect(),
        .lcdDriveEnable(), .pairReferenceSelect(), .pairBufferConfig(), .diffHysteresisEnable(), .dsiDataIn,
        .dsiOeIn, .dsiPinData, .wakeIn, .wakeOut(), .irqReq());
    iprs_pad_model u_pads (.padOut, .padOeN, .extLevel, .padIn);

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Small xorshift keeps the run repeatable
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bus cycles launch at the falling edge, one strobe per call
    task automatic wr(iprs_reg_t s, logic [2:0] p, logic [7:0] d);
        @(negedge clk_sys);
        cfgWrEn = 1'h1;
        cfgWrSel = s;
        cfgWrPin = p;
        cfgWrData = d;
        @(negedge clk_sys);
        cfgWrEn = 1'h0;
    endtask

    task automatic rd(iprs_reg_t s, logic [2:0] p, logic [7:0] e);
        @(negedge clk_sys);
        cfgRdEn = 1'h1;
        cfgRdSel = s;
        cfgRdPin = p;
        expQ.push_back({2'h0, e});
        @(negedge clk_sys);
        cfgRdEn = 1'h0;
    endtask

    // Pad data is compared at the edge after the probe
    task automatic pad(logic [7:0] e, logic [1:0] k = 2'h1);
        @(negedge clk_sys);
        probe = 1'h1;
        expQ.push_back({k, e});
        @(negedge clk_sys);
        probe = 1'h0;
    endtask

    // Monitor takes the oldest note when a result appears
    always @(posedge clk_sys) begin
        if (rdPend || probe) begin
            e9 = expQ.pop_front();
            case (e9[9:8])
                2'h1: check("padOut", padOut, e9[7:0]);
                2'h2: check("padOeN", padOeN, e9[7:0]);
                2'h3: check("dsiPinData", dsiPinData, e9[7:0]);
                default: check("cfgRdData", cfgRdData, e9[7:0]);
            endcase
        end
        rdPend <= cfgRdEn;
    end

    // Watchdog sized well beyond the sequence length
    initial begin
        #240000;
        err_total++;
        conclude();
    end

    initial begin
        {arst_n, cfgWrEn, cfgRdEn, wakeIn, probe} = 5'h00;
        {cfgWrPin, cfgRdPin, cfgWrData, extLevel, dsiDataIn, dsiOeIn} = 34'h0;
        cfgWrSel = REG_OUT_DATA;
        cfgRdSel = REG_OUT_DATA;
        repeat (3) @(negedge clk_sys);
        arst_n = 1'h1;
        rd(REG_OUT_DATA, 0, 8'h00);
        rv = xs();
        wr(REG_OUT_DATA, 0, rv);
        repeat (2) @(negedge clk_sys);
        pad(rv);
        m = xs();
        w = xs();
        wr(REG_MASK, 0, m);
        wr(REG_OUT_WIN, 0, w);
        rv = (rv & ~m) | (w & m);
        rd(REG_OUT_DATA, 0, rv);
        rd(REG_OUT_WIN, 0, rv & m);
        wr(REG_PIN_LEVEL, 0, ~rv);
        rd(REG_OUT_DATA, 0, rv);
        // Released pins show the outside level, so edges can be made
        wr(REG_LCD_DRIVE, 0, 8'hFF);
        extLevel = xs();
        dsiOeIn = 4'hA;
        repeat (2) @(negedge clk_sys);
        pad(8'hFF, 2'h2);
        rd(REG_PIN_LEVEL, 0, extLevel);
        rd(REG_LEVEL_WIN, 0, extLevel & m);
        pad(extLevel, 2'h3);
        // Synced path lags a level change by two edges
        wr(REG_DSYNC_IN, 0, 8'hFF);
        w = extLevel;
        extLevel = ~w;
        pad(w, 2'h3);
        pad(~w, 2'h3);
        wr(REG_OUT_DATA, 0, 8'h00);
        extLevel = 8'h00;
        // Every edge code on its own pin: rise, then fall
        for (int c = 0; c < 4; c++) begin
            m = 8'h01 << (2 * c);
            wakeIn = ~wakeIn;
            wr(REG_EDGE_TYPE, 3'(2 * c), 8'(c));
            rd(REG_IRQ_STATUS, 0, 8'h00);
            extLevel = m;
            repeat (3) @(negedge clk_sys);
            rd(REG_IRQ_STATUS, 0, (c % 2 == 1) ? m : 8'h00);
            rd(REG_SNAPSHOT, 0, m);
            rd(REG_IRQ_STATUS, 0, 8'h00);
            extLevel = 8'h00;
            repeat (3) @(negedge clk_sys);
            rd(REG_IRQ_STATUS, 0, (c >= 2) ? m : 8'h00);
        end
        // Bypassed pins follow the selected array signal
        wr(REG_BYPASS, 0, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            wr(REG_OSEL0, 0, k[0] ? 8'hFF : 8'h00);
            wr(REG_OSEL1, 0, k[1] ? 8'hFF : 8'h00);
            dsiDataIn = 4'(1 << k);
            repeat (3) @(negedge clk_sys);
            pad(8'hFF);
            dsiDataIn = ~dsiDataIn;
            repeat (3) @(negedge clk_sys);
            pad(8'h00);
        end
        // Synced bypass pins load the data register from the array
        wr(REG_OUT_SYNC, 0, 8'hFF);
        dsiDataIn = 4'h8;
        repeat (3) @(negedge clk_sys);
        rd(REG_OUT_DATA, 0, 8'hFF);
        pad(8'hFF);
        for (int r = 1; r < NUM_STORED; r++) begin
            rv = xs() & ((r == 11) ? 8'h0F : 8'hFF);
            wr(iprs_reg_t'(5'(r)), 0, rv);
            rd(iprs_reg_t'(5'(r)), 0, rv);
        end
        // Hardware capture would override the alias data bits
        wr(REG_OUT_SYNC, 0, 8'h00);
        wr(REG_PORT_ALIAS, 0, 8'h41);
        rd(REG_PIN_ALIAS, 5, 8'h41);
        rd(REG_BIDIR, 0, 8'hFF);
        rd(REG_OUT_DATA, 0, 8'hFF);
        // Let the last answer be compared before reset clears it
        @(negedge clk_sys);
        arst_n = 1'h0;
        @(negedge clk_sys);
        arst_n = 1'h1;
        rd(REG_OUT_DATA, 0, 8'h00);
        repeat (3) @(negedge clk_sys);
        conclude();
    end
endmodule // iprs_port_tb_top
